/* File: dpr_pkg.sv */
// Shared constants and mode types for the dual-port RAM clocking block.
package dpr_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int BYTES = DATA_W / BYTE_W;
  localparam int DEPTH = 256;
  localparam int PORTS = 2;

  // ---------------------------------------------------------------
  // Reset and fill values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] Q_RST = 16'h0000;
  localparam logic [DATA_W-1:0] UNDEF_FILL = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int MIN_WR_NS = 100;
  localparam int WIN_RAW = ((MIN_WR_NS / 2) + CLK_NS - 1) / CLK_NS;
  localparam int WIN_CYC = (WIN_RAW < 1) ? 1 : WIN_RAW;
  localparam int WIN_W = 2;

  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum {mem_single, mem_simple_dual, mem_true_dual} mem_mode_t;
  typedef enum {clk_independent, clk_in_out, clk_read_write, clk_single} clk_mode_t;
  typedef enum {rdw_old_data, return_undefined} rdw_mix_t;

endpackage : dpr_pkg

/* File: port_capture.sv */
// Input register group of one RAM port: address, data, byte enables and enables.
module port_capture (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic [dpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dpr_pkg::DATA_W-1:0] wdata_i,
  input wire logic [dpr_pkg::BYTES-1:0] be_i,
  input wire logic wren_i,
  input wire logic rden_i,
  output logic [dpr_pkg::ADDR_W-1:0] addr_o,
  output logic [dpr_pkg::DATA_W-1:0] wdata_o,
  output logic [dpr_pkg::BYTES-1:0] be_o,
  output logic wren_o,
  output logic rden_o,
  output logic take_o
);

  // ---------------------------------------------------------------
  // Capture on the port clock tick
  // ---------------------------------------------------------------
  // The clear acts without an edge; it loads constants only.
  always_ff @(posedge mclk_i or posedge clr_i) begin
    if (clr_i) begin
      addr_o <= dpr_pkg::ADDR_RST;
      wdata_o <= dpr_pkg::Q_RST;
      be_o <= '0;
      wren_o <= 1'b0;
      rden_o <= 1'b0;
    end else if (sys_rst_i) begin
      addr_o <= dpr_pkg::ADDR_RST;
      wdata_o <= dpr_pkg::Q_RST;
      be_o <= '0;
      wren_o <= 1'b0;
      rden_o <= 1'b0;
    end else if (tick_i && ce_i) begin
      addr_o <= addr_i;
      wdata_o <= wdata_i;
      be_o <= be_i;
      wren_o <= wren_i;
      rden_o <= rden_i;
    end
  end

  // Marks the cycle after a capture, which stands for the low clock phase.
  always_ff @(posedge mclk_i or posedge clr_i) begin
    if (clr_i) begin
      take_o <= 1'b0;
    end else if (sys_rst_i) begin
      take_o <= 1'b0;
    end else begin
      take_o <= tick_i && ce_i;
    end
  end

endmodule : port_capture

/* File: out_stage.sv */
// Optional data output register of one RAM port, with its own enable and clear.
module out_stage (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic bypass_i,
  input wire logic [dpr_pkg::DATA_W-1:0] d_i,
  input wire logic undef_i,
  output logic [dpr_pkg::DATA_W-1:0] q_o,
  output logic undef_o
);

  // ---------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------
  // Bypassed, the stage just retimes the read latch every cycle so the
  // pin still comes from a flop; registered, it loads on the output tick.
  always_ff @(posedge mclk_i or posedge clr_i) begin
    if (clr_i) begin
      q_o <= dpr_pkg::Q_RST;
      undef_o <= 1'b0;
    end else if (sys_rst_i) begin
      q_o <= dpr_pkg::Q_RST;
      undef_o <= 1'b0;
    end else if (bypass_i || (tick_i && ce_i)) begin
      q_o <= d_i;
      undef_o <= undef_i;
    end
  end

endmodule : out_stage

/* File: dp_ram_clocking.sv */
// Embedded block RAM with selectable clock schemes and read-during-write handling.
//
// What this block does
// - Independent clocks are allowed only with true dual-port memory.
// - Independent scheme: port A registers use clock A, port B use clock B.
// - Independent scheme: each port has its own enable and clear.
// - Input/output scheme is allowed for true and simple dual-port memory.
// - Input/output scheme: input clock loads inputs, output clock loads outputs.
// - Read/write scheme only for simple dual-port, separate read and write controls.
// - Read/write scheme: write clock loads write data, address and enable.
// - Read/write scheme: read clock loads read address, enable and output.
// - Single-port scheme; one block holds up to two independent single-port RAMs.
// - Every memory input is registered so writes are synchronous.
// - The block times its own write strobe from the clock.
// - Output registers may be bypassed.
// - Pseudo-asynchronous read in dual-port modes bypasses output registers.
// - Same-port read of the written address shows the new data.
// - True dual-port same-port byte-enabled write: masked bytes undefined, unmasked bytes new.
// - Mixed-port case: one port reads what the other writes, shared clock.
// - A parameter picks old data or undefined for mixed-port collisions.
// - With separate clocks the array write starts at the write clock fall.
// - A read before that fall returns the old contents.
// - A read just after the fall, within half a write cycle, is undefined.
// - Simple dual-port: with read enable low the output holds.
module dp_ram_clocking #(
  parameter dpr_pkg::mem_mode_t MEM_MODE = dpr_pkg::mem_true_dual,
  parameter dpr_pkg::clk_mode_t CLK_MODE = dpr_pkg::clk_independent,
  parameter bit OUT_REG_A = 1'b1,
  parameter bit OUT_REG_B = 1'b1,
  parameter bit PSEUDO_ASYNC = 1'b0,
  parameter dpr_pkg::rdw_mix_t RDW_MIXED = dpr_pkg::rdw_old_data
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic a_in_tick_i,
  input wire logic a_out_tick_i,
  input wire logic a_in_ce_i,
  input wire logic a_out_ce_i,
  input wire logic a_in_clr_i,
  input wire logic a_out_clr_i,
  input wire logic [dpr_pkg::ADDR_W-1:0] a_addr_i,
  input wire logic [dpr_pkg::DATA_W-1:0] a_wdata_i,
  input wire logic [dpr_pkg::BYTES-1:0] a_be_i,
  input wire logic a_wren_i,
  input wire logic a_rden_i,
  input wire logic b_in_tick_i,
  input wire logic b_out_tick_i,
  input wire logic b_in_ce_i,
  input wire logic b_out_ce_i,
  input wire logic b_in_clr_i,
  input wire logic b_out_clr_i,
  input wire logic [dpr_pkg::ADDR_W-1:0] b_addr_i,
  input wire logic [dpr_pkg::DATA_W-1:0] b_wdata_i,
  input wire logic [dpr_pkg::BYTES-1:0] b_be_i,
  input wire logic b_wren_i,
  input wire logic b_rden_i,
  output logic [dpr_pkg::DATA_W-1:0] a_q_o,
  output logic a_undef_o,
  output logic [dpr_pkg::DATA_W-1:0] b_q_o,
  output logic b_undef_o,
  output logic cfg_err_o
);

  localparam int AW = dpr_pkg::ADDR_W;
  localparam int DW = dpr_pkg::DATA_W;
  localparam int NB = dpr_pkg::BYTES;
  localparam int BW = dpr_pkg::BYTE_W;
  localparam int WW = dpr_pkg::WIN_W;

  // ---------------------------------------------------------------
  // Configuration check
  // ---------------------------------------------------------------
  // Scheme and memory mode must pair up; a bad pairing locks out writes.
  localparam bit CFG_OK =
    ((CLK_MODE == dpr_pkg::clk_independent) && (MEM_MODE == dpr_pkg::mem_true_dual)) ||
    ((CLK_MODE == dpr_pkg::clk_in_out) && (MEM_MODE != dpr_pkg::mem_single)) ||
    ((CLK_MODE == dpr_pkg::clk_read_write) && (MEM_MODE == dpr_pkg::mem_simple_dual)) ||
    ((CLK_MODE == dpr_pkg::clk_single) && (MEM_MODE == dpr_pkg::mem_single));
  localparam bit PA_OK = !PSEUDO_ASYNC || (MEM_MODE != dpr_pkg::mem_single);
  localparam bit IS_SINGLE = (MEM_MODE == dpr_pkg::mem_single);
  localparam bit IS_SDP = (MEM_MODE == dpr_pkg::mem_simple_dual);
  localparam bit IS_TDP = (MEM_MODE == dpr_pkg::mem_true_dual);
  localparam bit SPLIT_OUT = (CLK_MODE == dpr_pkg::clk_in_out);

  // Illegal setups are reported on a pin rather than silently misbehaving.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= !(CFG_OK && PA_OK);
    end
  end

  // ---------------------------------------------------------------
  // Per-port pin gathering and clock routing
  // ---------------------------------------------------------------
  logic [1:0] in_tick, out_tick, in_ce, out_ce, in_clr, out_clr;
  logic [1:0] wren_in, rden_in, take, cap_wren, cap_rden;
  logic [1:0] wr_go, rd_go, mix_now, mix_late, bypass, rd_undef_q, undef_w;
  logic [AW-1:0] addr_in [2];
  logic [AW-1:0] cap_addr [2];
  logic [AW-1:0] ea [2];
  logic [DW-1:0] wdata_in [2];
  logic [DW-1:0] cap_wdata [2];
  logic [DW-1:0] mem_rd [2];
  logic [DW-1:0] rdata_q [2];
  logic [DW-1:0] q_w [2];
  logic [NB-1:0] be_in [2];
  logic [NB-1:0] cap_be [2];
  logic [dpr_pkg::WIN_W-1:0] win_q [2];
  logic [AW-1:0] win_addr_q [2];
  logic [DW-1:0] mem [dpr_pkg::DEPTH];

  // Input clock per port; outputs share it unless the split scheme is chosen.
  assign in_tick = {b_in_tick_i, a_in_tick_i};
  assign in_ce = {b_in_ce_i, a_in_ce_i};
  assign in_clr = {b_in_clr_i, a_in_clr_i};
  assign out_tick = SPLIT_OUT ? {b_out_tick_i, a_out_tick_i} : in_tick;
  assign out_ce = SPLIT_OUT ? {b_out_ce_i, a_out_ce_i} : in_ce;
  assign out_clr = SPLIT_OUT ? {b_out_clr_i, a_out_clr_i} : in_clr;
  assign wren_in = {b_wren_i, a_wren_i};
  assign rden_in = {b_rden_i, a_rden_i};
  assign addr_in[0] = a_addr_i;
  assign addr_in[1] = b_addr_i;
  assign wdata_in[0] = a_wdata_i;
  assign wdata_in[1] = b_wdata_i;
  assign be_in[0] = a_be_i;
  assign be_in[1] = b_be_i;
  assign bypass = {!OUT_REG_B || PSEUDO_ASYNC, !OUT_REG_A || PSEUDO_ASYNC};

  // ---------------------------------------------------------------
  // Byte merge for a same-port read of the address being written
  // ---------------------------------------------------------------
  // In true dual-port mode masked bytes are undefined; the stored byte is shown for them.
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [NB-1:0] be);
    logic [DW-1:0] r;
    r = old_v;
    for (int k = 0; k < NB; k++) begin
      if (be[k]) begin
        r[k*BW +: BW] = new_v[k*BW +: BW];
      end
    end
    return r;
  endfunction : merge

  // ---------------------------------------------------------------
  // Memory array
  // ---------------------------------------------------------------
  // Writes land at the end of the cycle after capture, standing for the
  // falling edge; port A is written last so it wins a clash, which user
  // logic must avoid anyway. No reset or clear touches the array.
  always_ff @(posedge mclk_i) begin
    for (int k = 0; k < NB; k++) begin
      if (wr_go[1] && cap_be[1][k]) begin
        mem[ea[1]][k*BW +: BW] <= cap_wdata[1][k*BW +: BW];
      end
      if (wr_go[0] && cap_be[0][k]) begin
        mem[ea[0]][k*BW +: BW] <= cap_wdata[0][k*BW +: BW];
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions shared by both ports
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_port_a_commit;
    wr_go[0] && (cap_be[0] == '1) |=> mem[$past(ea[0])] == $past(cap_wdata[0]);
  endproperty
  a_port_a_commit: assert property (p_port_a_commit)
    else $error("port A write did not reach the array");

  property p_bad_cfg_blocks;
    cfg_err_o |-> (wr_go == 2'b00);
  endproperty
  a_bad_cfg_blocks: assert property (p_bad_cfg_blocks)
    else $error("write accepted under an illegal configuration");

  property p_sdp_roles;
    IS_SDP |-> !wr_go[1] && !rd_go[0];
  endproperty
  a_sdp_roles: assert property (p_sdp_roles)
    else $error("simple dual-port port roles violated");

  // ---------------------------------------------------------------
  // Per-port logic
  // ---------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int O = 1 - p;
    localparam bit WR_OK = !(IS_SDP && (p == 1));
    localparam bit RD_OK = !(IS_SDP && (p == 0));

    // Every input passes a register before it reaches the array.
    port_capture u_cap (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(in_tick[p]),
      .ce_i(in_ce[p]),
      .clr_i(in_clr[p]),
      .addr_i(addr_in[p]),
      .wdata_i(wdata_in[p]),
      .be_i(be_in[p]),
      .wren_i(wren_in[p]),
      .rden_i(rden_in[p]),
      .addr_o(cap_addr[p]),
      .wdata_o(cap_wdata[p]),
      .be_o(cap_be[p]),
      .wren_o(cap_wren[p]),
      .rden_o(cap_rden[p]),
      .take_o(take[p])
    );

    // In single-port mode each port owns one half of the block.
    assign ea[p] = IS_SINGLE ? {1'(p), cap_addr[p][AW-2:0]} : cap_addr[p];
    assign wr_go[p] = take[p] && cap_wren[p] && WR_OK && CFG_OK && PA_OK;
    assign rd_go[p] = take[p] && cap_rden[p] && RD_OK;
    assign mem_rd[p] = mem[ea[p]];
    assign mix_now[p] = !IS_SINGLE && wr_go[O] && (ea[O] == ea[p]);
    assign mix_late[p] = !IS_SINGLE && (win_q[O] != '0) && (win_addr_q[O] == ea[p]);

    // Tracks the unsafe span after this port's write for the other port.
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        win_q[p] <= '0;
        win_addr_q[p] <= dpr_pkg::ADDR_RST;
      end else if (wr_go[p]) begin
        win_q[p] <= WW'(dpr_pkg::WIN_CYC);
        win_addr_q[p] <= ea[p];
      end else if (win_q[p] != '0) begin
        win_q[p] <= win_q[p] - 1'b1;
      end
    end

    // Read latch: the array value seen at the end of the cycle after capture.
    // Old data falls out naturally, since the other write lands only at
    // the edge that closes this cycle.
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        rdata_q[p] <= dpr_pkg::Q_RST;
        rd_undef_q[p] <= 1'b0;
      end else if (rd_go[p]) begin
        if (wr_go[p]) begin
          rdata_q[p] <= merge(mem_rd[p], cap_wdata[p], cap_be[p]);
          rd_undef_q[p] <= IS_TDP && (cap_be[p] != '1);
        end else if (mix_now[p] && (RDW_MIXED == dpr_pkg::return_undefined)) begin
          rdata_q[p] <= dpr_pkg::UNDEF_FILL;
          rd_undef_q[p] <= 1'b1;
        end else if (mix_late[p]) begin
          rdata_q[p] <= mem_rd[p];
          rd_undef_q[p] <= 1'b1;
        end else begin
          rdata_q[p] <= mem_rd[p];
          rd_undef_q[p] <= 1'b0;
        end
      end
    end // With no read the latch holds

    out_stage u_out (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(out_tick[p]),
      .ce_i(out_ce[p]),
      .clr_i(out_clr[p]),
      .bypass_i(bypass[p]),
      .d_i(rdata_q[p]),
      .undef_i(rd_undef_q[p]),
      .q_o(q_w[p]),
      .undef_o(undef_w[p])
    );

    // Assertions for this port.
    sequence s_bypass_run;
      bypass[p] && !out_clr[p] ##1 !out_clr[p];
    endsequence

    property p_bypass_follow;
      s_bypass_run |-> q_w[p] == $past(rdata_q[p]);
    endproperty
    a_bypass_follow: assert property (p_bypass_follow)
      else $error("bypassed output did not follow the read latch");

    property p_same_port_new;
      rd_go[p] && wr_go[p] && (cap_be[p] == '1) |=> rdata_q[p] == $past(cap_wdata[p]);
    endproperty
    a_same_port_new: assert property (p_same_port_new)
      else $error("same-port read did not show new data");

    property p_hold_idle;
      !rd_go[p] |=> $stable(rdata_q[p]);
    endproperty
    a_hold_idle: assert property (p_hold_idle)
      else $error("read data changed without a read");

    sequence s_plain_read;
      rd_go[p] && !wr_go[p] && !mix_late[p] &&
        (!mix_now[p] || (RDW_MIXED == dpr_pkg::rdw_old_data));
    endsequence

    property p_old_data;
      s_plain_read |=> rdata_q[p] == $past(mem_rd[p]) && !rd_undef_q[p];
    endproperty
    a_old_data: assert property (p_old_data)
      else $error("read did not return the old contents");

    property p_mixed_undef;
      rd_go[p] && !wr_go[p] && mix_now[p] && (RDW_MIXED == dpr_pkg::return_undefined)
        |=> rd_undef_q[p] && (rdata_q[p] == dpr_pkg::UNDEF_FILL);
    endproperty
    a_mixed_undef: assert property (p_mixed_undef)
      else $error("mixed-port collision not flagged undefined");

    property p_in_clear;
      in_clr[p] |-> (cap_addr[p] == '0) && !cap_wren[p] && !take[p];
    endproperty
    a_in_clear: assert property (p_in_clear)
      else $error("input group not zero under clear");

    property p_out_clear;
      out_clr[p] |-> (q_w[p] == dpr_pkg::Q_RST) && !undef_w[p];
    endproperty
    a_out_clear: assert property (p_out_clear)
      else $error("output group not zero under clear");
  end

  // ---------------------------------------------------------------
  // Output pins
  // ---------------------------------------------------------------
  // Each pin is the output flop of its port's output stage.
  assign a_q_o = q_w[0];
  assign a_undef_o = undef_w[0];
  assign b_q_o = q_w[1];
  assign b_undef_o = undef_w[1];

endmodule : dp_ram_clocking

/* File: dpr_user_port.sv */
// Behavioural model of the user logic that drives one port of the RAM.
module dpr_user_port (
  input wire logic mclk_i,
  output logic tick_o,
  output logic wren_o,
  output logic rden_o,
  output logic [dpr_pkg::ADDR_W-1:0] addr_o,
  output logic [dpr_pkg::DATA_W-1:0] wdata_o,
  output logic [dpr_pkg::BYTES-1:0] be_o
);

  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  // Address and data lines start in a pattern that differs from any value used later.
  initial begin
    tick_o = 1'b0;
    wren_o = 1'b0;
    rden_o = 1'b0;
    addr_o = 8'h5a;
    wdata_o = 16'ha5c3;
    be_o = 2'h2;
  end

  // ---------------------------------------------------------------
  // One access of one cycle
  // ---------------------------------------------------------------
  // Waits lag idle cycles, so the model can answer promptly or slowly.
  // After the access the address, data and byte enables show their inverse, because the RAM
  // may not see the last value once the tick has gone.
  task automatic access(input logic we, input logic re, input logic [7:0] ad,
                        input logic [15:0] d, input logic [1:0] b, input int lag);
    repeat (lag) @(posedge mclk_i);
    @(posedge mclk_i);
    tick_o <= 1'b1;
    wren_o <= we;
    rden_o <= re;
    addr_o <= ad;
    wdata_o <= d;
    be_o <= b;
    @(posedge mclk_i);
    tick_o <= 1'b0;
    wren_o <= 1'b0;
    rden_o <= 1'b0;
    addr_o <= ~ad;
    wdata_o <= ~d;
    be_o <= ~b;
  endtask : access

endmodule : dpr_user_port

/* File: dp_ram_clocking_tb_top.sv */
// Self-checking testbench of the dual-port RAM clocking block.
module dp_ram_clocking_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic a_in_ce = 1'b1;
  logic b_in_ce = 1'b1;
  logic a_in_clr = 1'b0;
  logic b_in_clr = 1'b0;
  logic out_tick = 1'b0;
  logic out_ce = 1'b1;
  logic out_clr = 1'b0;
  logic a_tick, a_wren, a_rden, b_tick, b_wren, b_rden;
  logic [7:0] a_addr, b_addr;
  logic [15:0] a_wdata, b_wdata, a_q, b_q;
  logic [1:0] a_be, b_be;
  logic a_undef, b_undef, cfg_err;
  logic [15:0] u_a_q, u_b_q;
  logic u_b_undef, u_cfg_err;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 mclk_i = ~mclk_i;

  // The output tick is unused in this scheme but still kept moving.
  always @(posedge mclk_i) out_tick <= ~out_tick;

  dpr_user_port a_user_u (.mclk_i(mclk_i), .tick_o(a_tick), .wren_o(a_wren),
    .rden_o(a_rden), .addr_o(a_addr), .wdata_o(a_wdata), .be_o(a_be));
  dpr_user_port b_user_u (.mclk_i(mclk_i), .tick_o(b_tick), .wren_o(b_wren),
    .rden_o(b_rden), .addr_o(b_addr), .wdata_o(b_wdata), .be_o(b_be));

  // Output registers bypassed so read data lands two edges after capture.
  dp_ram_clocking #(.OUT_REG_A(1'b0), .OUT_REG_B(1'b0)) dut_u (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .a_in_tick_i(a_tick), .a_out_tick_i(out_tick), .a_in_ce_i(a_in_ce),
    .a_out_ce_i(out_ce), .a_in_clr_i(a_in_clr), .a_out_clr_i(out_clr),
    .a_addr_i(a_addr), .a_wdata_i(a_wdata), .a_be_i(a_be), .a_wren_i(a_wren),
    .a_rden_i(a_rden),
    .b_in_tick_i(b_tick), .b_out_tick_i(out_tick), .b_in_ce_i(b_in_ce),
    .b_out_ce_i(out_ce), .b_in_clr_i(b_in_clr), .b_out_clr_i(out_clr),
    .b_addr_i(b_addr), .b_wdata_i(b_wdata), .b_be_i(b_be), .b_wren_i(b_wren),
    .b_rden_i(b_rden),
    .a_q_o(a_q), .a_undef_o(a_undef), .b_q_o(b_q), .b_undef_o(b_undef),
    .cfg_err_o(cfg_err));

  // Second copy on the same stimulus: split output clocks, pseudo-asynchronous
  // read and undefined mixed reads, so those decodes are exercised too.
  dp_ram_clocking #(.CLK_MODE(dpr_pkg::clk_in_out), .PSEUDO_ASYNC(1'b1),
    .RDW_MIXED(dpr_pkg::return_undefined)) undef_dut_u (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .a_in_tick_i(a_tick), .a_out_tick_i(out_tick), .a_in_ce_i(a_in_ce),
    .a_out_ce_i(out_ce), .a_in_clr_i(a_in_clr), .a_out_clr_i(out_clr),
    .a_addr_i(a_addr), .a_wdata_i(a_wdata), .a_be_i(a_be), .a_wren_i(a_wren),
    .a_rden_i(a_rden),
    .b_in_tick_i(b_tick), .b_out_tick_i(out_tick), .b_in_ce_i(b_in_ce),
    .b_out_ce_i(out_ce), .b_in_clr_i(b_in_clr), .b_out_clr_i(out_clr),
    .b_addr_i(b_addr), .b_wdata_i(b_wdata), .b_be_i(b_be), .b_wren_i(b_wren),
    .b_rden_i(b_rden),
    .a_q_o(u_a_q), .a_undef_o(), .b_q_o(u_b_q), .b_undef_o(u_b_undef),
    .cfg_err_o(u_cfg_err));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Read data settles two edges after the capture edge.
  task automatic settle;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check(a_q, 16'h0000);
    check(b_q, 16'h0000);
    check({13'h0, a_undef, b_undef, cfg_err}, 16'h0000);
    check({15'h0, u_cfg_err}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_same_port;
    a_user_u.access(1'b1, 1'b1, 8'h10, 16'h1234, 2'h3, 0);
    @(posedge mclk_i);
    @(negedge mclk_i);
    check(a_q, 16'h0000);
    @(posedge mclk_i);
    @(negedge mclk_i);
    check(a_q, 16'h1234);
    check({15'h0, a_undef}, 16'h0000);
    b_user_u.access(1'b1, 1'b1, 8'h11, 16'hbeef, 2'h3, 2);
    settle();
    check(b_q, 16'hbeef);
    $display("test same port done");
  endtask : t_same_port

  task automatic t_byte_en;
    a_user_u.access(1'b1, 1'b1, 8'h10, 16'haa55, 2'h1, 0);
    settle();
    check({8'h0, a_q[7:0]}, 16'h0055);
    check({15'h0, a_undef}, 16'h0001);
    a_user_u.access(1'b0, 1'b1, 8'h10, 16'h0000, 2'h0, 0);
    settle();
    check(a_q, 16'h1255);
    $display("test byte enable done");
  endtask : t_byte_en

  // The two ports never write one address together here.
  task automatic t_mixed;
    fork
      a_user_u.access(1'b1, 1'b0, 8'h11, 16'h0f0f, 2'h3, 0);
      b_user_u.access(1'b0, 1'b1, 8'h11, 16'h0000, 2'h0, 0);
    join
    settle();
    check(b_q, 16'hbeef);
    check({15'h0, b_undef}, 16'h0000);
    check(u_b_q, 16'h0000);
    check({15'h0, u_b_undef}, 16'h0001);
    fork
      a_user_u.access(1'b1, 1'b0, 8'h11, 16'h7777, 2'h3, 0);
      b_user_u.access(1'b0, 1'b1, 8'h11, 16'h0000, 2'h0, 1);
    join
    settle();
    check(b_q, 16'h7777);
    check({15'h0, b_undef}, 16'h0001);
    fork
      a_user_u.access(1'b1, 1'b0, 8'h11, 16'h8888, 2'h3, 0);
      b_user_u.access(1'b0, 1'b1, 8'h11, 16'h0000, 2'h0, 2);
    join
    settle();
    check(b_q, 16'h8888);
    check({15'h0, b_undef}, 16'h0000);
    $display("test mixed port done");
  endtask : t_mixed

  task automatic t_hold;
    a_user_u.access(1'b0, 1'b0, 8'h11, 16'h0000, 2'h0, 0);
    settle();
    check(a_q, 16'h1255);
    $display("test hold done");
  endtask : t_hold

  task automatic t_enable;
    @(posedge mclk_i);
    a_in_ce <= 1'b0;
    fork
      a_user_u.access(1'b1, 1'b1, 8'h10, 16'hdead, 2'h3, 0);
      b_user_u.access(1'b0, 1'b1, 8'h10, 16'h0000, 2'h0, 0);
    join
    settle();
    check(a_q, 16'h1255);
    check(b_q, 16'h1255);
    @(posedge mclk_i);
    a_in_ce <= 1'b1;
    $display("test enable done");
  endtask : t_enable

  task automatic t_clear;
    @(posedge mclk_i);
    a_in_clr <= 1'b1;
    @(negedge mclk_i);
    check(a_q, 16'h0000);
    check(b_q, 16'h1255);
    check(u_a_q, 16'h1255);
    @(posedge mclk_i);
    a_in_clr <= 1'b0;
    out_clr <= 1'b1;
    @(negedge mclk_i);
    check(u_a_q, 16'h0000);
    check(b_q, 16'h1255);
    @(posedge mclk_i);
    out_clr <= 1'b0;
    a_user_u.access(1'b0, 1'b1, 8'h10, 16'h0000, 2'h0, 0);
    settle();
    check(a_q, 16'h1255);
    check(u_a_q, 16'h1255);
    $display("test clear done");
  endtask : t_clear

  // ---------------------------------------------------------------
  // Sequence and hang guard
  // ---------------------------------------------------------------
  // The whole sequence takes well under a hundred cycles.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_same_port();
    t_byte_en();
    t_mixed();
    t_hold();
    t_enable();
    t_clear();
    give_verdict();
  end

endmodule : dp_ram_clocking_tb_top
